// File: src/pbio_params.svh
// Constants for the prototype board I/O ports and its host driver
`ifndef PBIO_PARAMS_SVH
`define PBIO_PARAMS_SVH

// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define PBIO_ADDR_W        6
`define PBIO_DATA_W        8
`define PBIO_PORTS         4
`define PBIO_MAX_BOARDS    8

// ---------------------------------------------------------------
// Timing, at a 100 ns clock
// ---------------------------------------------------------------
`define PBIO_CLK_NS        100
`define PBIO_OUT_VALID_NS  30
`define PBIO_SAMPLE_US     50
`define PBIO_BUSY_US       100
// Sample delay rounds down: a longest wait
`define PBIO_SAMPLE_CYC    ((`PBIO_SAMPLE_US * 1000) / `PBIO_CLK_NS)
// Host holds each strobe this long at least before it looks at busy.
// A busy raised in answer to the strobe crosses the board's input flops,
// its busy register and the host's own flops; shorter and the host would
// take stale data.
`define PBIO_STROBE_CYC    8

// ---------------------------------------------------------------
// Host APB register map (byte offsets)
// ---------------------------------------------------------------
`define PBIO_REG_CTRL      12'h000
`define PBIO_REG_STATUS    12'h004
`define PBIO_REG_WDATA     12'h008
`define PBIO_REG_RDATA     12'h00c
// Control fields: go, write flag, bus address
`define PBIO_CTRL_GO       0
`define PBIO_CTRL_WR       1
`define PBIO_CTRL_ADDR_LO  8
// Status fields
`define PBIO_STAT_BUSY     0
`define PBIO_STAT_LINE     1

`endif

// File: src/pbio_pkg.sv
// Types shared by both ends of the prototype board link
package pbio_pkg;
   `include "pbio_params.svh"

   // Bus address and data types
   typedef logic [`PBIO_ADDR_W-1:0] pbio_addr_t;
   typedef logic [`PBIO_DATA_W-1:0] pbio_data_t;

   // Host cycle states
   typedef enum logic [2:0] {
      PBIO_IDLE  = 3'b000,
      PBIO_SETUP = 3'b001,
      PBIO_STRB  = 3'b010,
      PBIO_WAIT  = 3'b011,
      PBIO_DONE  = 3'b100
   } pbio_host_e;
endpackage

// File: src/pbio_bus_if.sv
// Parallel cable bus between host driver card and I/O board
`timescale 1ns/1ns
interface pbio_bus_if;
   import pbio_pkg::*;
   pbio_addr_t addr;         // Bus address from host
   pbio_data_t wdata;        // Host drives data lines
   logic       wdata_oe;     // Host drive enable
   pbio_data_t rdata;        // Board drives data lines
   logic       rdata_oe;     // Board drive enable
   logic       rd_n;         // Read command, active low
   logic       wr;           // Write command, active high
   logic       busy_out;     // Board drives busy
   logic       busy_oe;      // Board busy drive enable
   pbio_data_t data;         // Resolved data lines
   logic       busy;         // Resolved busy, open line pulled low

   assign data = rdata_oe ? rdata : (wdata_oe ? wdata : '1);
   assign busy = busy_oe & busy_out;

   modport host (output addr, wdata, wdata_oe, rd_n, wr, input data, busy);
   modport dev  (input addr, rd_n, wr, data, output rdata, rdata_oe, busy_out, busy_oe);
endinterface

// File: src/pbio_port.sv
// One 8-bit port: output latch, input sample, readback and strobes
`timescale 1ns/1ns
`include "pbio_params.svh"
module pbio_port
   import pbio_pkg::*;
#(
   parameter int SAMPLE_CYC = `PBIO_SAMPLE_CYC
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        sel,        // This port addressed
   input  wire logic        rd_cyc,     // Read cycle active, synchronised
   input  wire logic        wr_cyc,     // Write cycle active, synchronised
   input  wire pbio_data_t  wdata,      // Bus data, synchronised
   input  wire pbio_data_t  pin_in,     // User inputs, synchronised
   input  wire logic        jumper,     // Readback jumper fitted
   output pbio_data_t       out_latch,  // Latched outputs
   output logic             rd_strobe_n,// Port read strobe
   output logic             wr_strobe,  // Port write strobe
   output pbio_data_t       rd_byte,    // Sampled read value
   output logic             rd_ready    // Sampled value valid
);
   // ---------------------------------------------------------------
   // Strobes
   // ---------------------------------------------------------------
   localparam int CW = $clog2(SAMPLE_CYC + 1);
   logic [CW-1:0] cnt;       // Cycles since read strobe fell

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rd_strobe_n <= 1'b1;
         wr_strobe   <= 1'b0;
      end else begin
         rd_strobe_n <= !(sel & rd_cyc);
         wr_strobe   <= sel & wr_cyc;
      end
   end

   // ---------------------------------------------------------------
   // Output latch
   // ---------------------------------------------------------------
   // capture on strobe rise
   always_ff @(posedge clock) begin
      if (!resetn) begin
         out_latch <= '0;
      end else if (sel & wr_cyc & !wr_strobe) begin
         // Data lands with the strobe edge, well within 30 ns of the clock
         out_latch <= wdata;
      end
   end

   // ---------------------------------------------------------------
   // Input sampling, not latched by a strobe
   // ---------------------------------------------------------------
   // sample after delay
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cnt      <= '0;
         rd_ready <= 1'b0;
         rd_byte  <= '0;
      end else if (rd_strobe_n) begin
         // Strobe idle: restart the delay
         cnt      <= '0;
         rd_ready <= 1'b0;
      end else if (cnt != CW'(SAMPLE_CYC)) begin
         cnt <= cnt + 1'b1;
      end else if (!rd_ready) begin
         rd_ready <= 1'b1;
         rd_byte  <= jumper ? out_latch : pin_in;
      end
   end
endmodule

// File: src/pbio_board.sv
// I/O board end: address decode, four ports, bus drive and busy
`timescale 1ns/1ns
`include "pbio_params.svh"
// How it works
// - four 8-bit ports, 32 in, 32 out
// - each port has own read/write strobes
// - user busy holds off host
// - base address is sum of ON switches
// - integrator gives boards distinct ranges
// - one host reaches up to eight boards
// - jumper makes read return output latch
// - output latched on write strobe rise
// - inputs sampled about 50 us after read
// - user holds input until read ends
// - read strobes low, write strobes high
// - four consecutive addresses, one byte each
module pbio_board
   import pbio_pkg::*;
#(
   parameter int NPORTS     = `PBIO_PORTS,
   parameter int SAMPLE_CYC = `PBIO_SAMPLE_CYC
) (
   input  wire logic                      clock,
   input  wire logic                      resetn,
   pbio_bus_if.dev                        bus,
   input  wire pbio_addr_t                addr_switch,  // ON switches as ones
   input  wire logic [NPORTS-1:0]         readback_jumper, // Bit n is jumper of port n
   input  wire logic [NPORTS*8-1:0]       user_in,      // User input lines
   input  wire logic                      user_busy,    // User asks host to wait
   output logic      [NPORTS*8-1:0]       user_out,     // Latched outputs
   output logic      [NPORTS-1:0]         rd_strobe_n,  // Per-port read strobes
   output logic      [NPORTS-1:0]         wr_strobe     // Per-port write strobes
);
   // ---------------------------------------------------------------
   // Input synchronisers, two flops each
   // ---------------------------------------------------------------
   logic [`PBIO_ADDR_W+`PBIO_DATA_W+3+NPORTS*8+NPORTS-1:0] s1, s2; // Raw and stable
   pbio_addr_t         a_s;     // Address synchronised
   pbio_data_t         d_s;     // Data synchronised
   logic               rdn_s;   // Read command synchronised
   logic               wr_s;    // Write command synchronised
   logic               ub_s;    // User busy synchronised
   logic [NPORTS*8-1:0] in_s;   // User inputs synchronised
   logic [NPORTS-1:0]  jp_s;    // Jumpers synchronised
   pbio_addr_t         base;    // Board base, reloaded from the switches every cycle out of reset

   // Pins and cable lines come from another domain
   always_ff @(posedge clock) begin
      s1 <= {bus.addr, bus.data, bus.rd_n, bus.wr, user_busy, user_in, readback_jumper};
      s2 <= s1;
   end
   assign {a_s, d_s, rdn_s, wr_s, ub_s, in_s, jp_s} = s2;

   // Switches are pins too, so they pass two flops before use
   pbio_addr_t sw1, sw2;        // Switch synchroniser
   always_ff @(posedge clock) begin
      sw1 <= addr_switch;
      sw2 <= sw1;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         base <= '0;
      end else begin
         // ON switches read as ones, so the word is the sum of their weights
         base <= sw2;
      end
   end

   // ---------------------------------------------------------------
   // Port decode
   // ---------------------------------------------------------------
   pbio_addr_t          off;     // Offset from base
   logic [NPORTS-1:0]   sel;     // One-hot port select
   pbio_data_t          rbyte [NPORTS];
   logic [NPORTS-1:0]   rrdy;    // Per-port sample valid
   assign off = a_s - base;

   always_comb begin
      sel = '0;
      if (off < `PBIO_ADDR_W'(NPORTS)) begin
         sel[off[$clog2(NPORTS)-1:0]] = 1'b1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NPORTS; gi++) begin : g_port
         pbio_port #(.SAMPLE_CYC(SAMPLE_CYC)) u_port (
            .clock       (clock),
            .resetn      (resetn),
            .sel         (sel[gi]),
            .rd_cyc      (!rdn_s),
            .wr_cyc      (wr_s),
            .wdata       (d_s),
            .pin_in      (in_s[gi*8 +: 8]),
            .jumper      (jp_s[gi]),
            .out_latch   (user_out[gi*8 +: 8]),
            .rd_strobe_n (rd_strobe_n[gi]),
            .wr_strobe   (wr_strobe[gi]),
            .rd_byte     (rbyte[gi]),
            .rd_ready    (rrdy[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Bus drive and busy
   // ---------------------------------------------------------------
   pbio_data_t next_rdata;   // Selected port byte
   always_comb begin
      next_rdata = '0;
      for (int i = 0; i < NPORTS; i++) begin
         if (sel[i]) begin
            next_rdata = rbyte[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         bus.rdata    <= '0;
         bus.rdata_oe <= 1'b0;
      end else begin
         bus.rdata    <= next_rdata;
         bus.rdata_oe <= |(sel & ~rd_strobe_n);
      end
   end

   // busy until sample and user done
   always_ff @(posedge clock) begin
      if (!resetn) begin
         bus.busy_out <= 1'b0;
         bus.busy_oe  <= 1'b0;
      end else begin
         // Busy also covers the read sample delay so host waits for valid data
         bus.busy_out <= ub_s | |(~rd_strobe_n & ~rrdy);
         bus.busy_oe  <= ub_s | |(~rd_strobe_n & ~rrdy);
      end
   end
endmodule

// File: src/pbio_host.sv
// Host driver end: APB registers and bus cycle sequencer
`timescale 1ns/1ns
`include "pbio_params.svh"
module pbio_host
   import pbio_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   pbio_bus_if.host         bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   // ---------------------------------------------------------------
   // Registers and sequencer state
   // ---------------------------------------------------------------
   pbio_host_e  st;          // Cycle state
   logic        op_wr;       // Pending cycle is a write
   pbio_addr_t  op_addr;     // Pending bus address
   pbio_data_t  op_wdata;    // Byte to write
   pbio_data_t  rd_val;      // Byte on data lines at end of last cycle, read or write
   logic [3:0]  cnt;         // Strobe hold count
   logic        b1, b2;      // Busy synchroniser
   pbio_data_t  d1, d2;      // Data synchroniser
   logic        go;          // Start request from software
   wire         acc = psel & penable;

   always_ff @(posedge clock) begin
      b1 <= bus.busy;
      b2 <= b1;
      d1 <= bus.data;
      d2 <= d1;
   end

   // ---------------------------------------------------------------
   // APB slave, zero wait
   // ---------------------------------------------------------------
   assign go = acc & pwrite & (paddr == `PBIO_REG_CTRL) & pwdata[`PBIO_CTRL_GO] & (st == PBIO_IDLE);
   always_ff @(posedge clock) begin
      if (!resetn) begin
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         op_wr    <= 1'b0;
         op_addr  <= '0;
         op_wdata <= '0;
      end else begin
         pready  <= psel & !penable;
         pslverr <= psel & !penable & (paddr > `PBIO_REG_RDATA);
         prdata  <= '0;
         if (psel & !penable & !pwrite) begin
            case (paddr)
               `PBIO_REG_CTRL:   prdata <= {18'h0, op_addr, 6'h0, op_wr, 1'b0};
               `PBIO_REG_STATUS: prdata <= {30'h0, b2, st != PBIO_IDLE};
               `PBIO_REG_WDATA:  prdata <= {24'h0, op_wdata};
               `PBIO_REG_RDATA:  prdata <= {24'h0, rd_val};
               default:          prdata <= '0;
            endcase
         end
         if (go) begin
            op_wr   <= pwdata[`PBIO_CTRL_WR];
            op_addr <= pwdata[`PBIO_CTRL_ADDR_LO +: `PBIO_ADDR_W];
         end
         if (acc & pwrite & (paddr == `PBIO_REG_WDATA)) begin
            op_wdata <= pwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus cycle: address, strobe, wait out busy, release
   // ---------------------------------------------------------------
   // six address bits reach eight boards
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st           <= PBIO_IDLE;
         cnt          <= '0;
         rd_val       <= '0;
         bus.addr     <= '0;
         bus.wdata    <= '0;
         bus.wdata_oe <= 1'b0;
         bus.rd_n     <= 1'b1;
         bus.wr       <= 1'b0;
      end else begin
         case (st)
            PBIO_IDLE: begin
               if (go) begin
                  st <= PBIO_SETUP;
               end
            end
            PBIO_SETUP: begin
               bus.addr     <= op_addr;
               bus.wdata    <= op_wdata;
               bus.wdata_oe <= op_wr;
               st           <= PBIO_STRB;
               cnt          <= '0;
            end
            PBIO_STRB: begin
               bus.rd_n <= op_wr;
               bus.wr   <= op_wr;
               cnt      <= cnt + 1'b1;
               // Give the board time to raise busy through its synchronisers
               if (cnt == 4'(`PBIO_STROBE_CYC)) begin
                  st <= PBIO_WAIT;
               end
            end
            PBIO_WAIT: begin
               if (!b2) begin
                  rd_val   <= d2;
                  bus.rd_n <= 1'b1;
                  bus.wr   <= 1'b0;
                  st       <= PBIO_DONE;
               end
            end
            PBIO_DONE: begin
               bus.wdata_oe <= 1'b0;
               st           <= PBIO_IDLE;
            end
            default: st <= PBIO_IDLE;
         endcase
      end
   end
endmodule

// File: tb/pbio_checker.sv
// Protocol checks on the cable bus joining host end and board end
`timescale 1ns/1ns
module pbio_checker
   import pbio_pkg::*;
#(
   parameter int BASE = 24
) (
   input wire logic       clock,
   input wire logic       resetn,
   input wire pbio_addr_t addr,
   input wire pbio_data_t wdata,
   input wire logic       wdata_oe,
   input wire pbio_data_t rdata,
   input wire logic       rdata_oe,
   input wire logic       rd_n,
   input wire logic       wr,
   input wire logic       busy_out,
   input wire logic       busy_oe,
   input wire pbio_data_t data,
   input wire logic       busy
);
   // ------------------------------------------------
   // Shared clocking and helpers
   // ------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic own;  // Address lands on one of our four ports
   assign own = (int'(addr) >= BASE) && (int'(addr) < BASE + 4);
   sequence s_rd_start;
      $fell(rd_n) && own;
   endsequence
   sequence s_rd_held;
      !rd_n ##1 !rd_n;
   endsequence
   sequence s_wr_held;
      wr ##1 wr;
   endsequence
   property p_one_cmd;
      !(!rd_n && wr);
   endproperty
   // Board drive may lag the strobe through the synchronisers, so judge its start
   property p_rose_oe;
      $rose(rdata_oe) |-> !rd_n && own;
   endproperty
   property p_oe_off;
      $rose(rd_n) |-> ##[0:5] !rdata_oe;
   endproperty
   property p_oe_on;
      s_rd_start |-> ##[1:24] rdata_oe;
   endproperty
   property p_busy_rise;
      s_rd_start |-> ##[1:6] busy;
   endproperty
   property p_hold;
      ((!rd_n || wr) && busy) |=> (!rd_n || wr);
   endproperty
   property p_sample_len;
      s_rd_start |-> !rd_n [*8];
   endproperty
   property p_addr_rd;
      s_rd_held |-> $stable(addr);
   endproperty
   property p_data_wr;
      s_wr_held |-> $stable(wdata) && $stable(addr);
   endproperty
   property p_wr_drive;
      wr |-> wdata_oe;
   endproperty
   a_one_cmd: assert property (p_one_cmd) else $error("read and write strobes together");
   a_rose_oe: assert property (p_rose_oe) else $error("board drove data outside own read");
   a_oe_off: assert property (p_oe_off) else $error("board kept driving after read");
   a_oe_on: assert property (p_oe_on) else $error("board never drove own read");
   a_busy_rise: assert property (p_busy_rise) else $error("busy missing on port read");
   a_hold: assert property (p_hold) else $error("host released while busy");
   a_sample_len: assert property (p_sample_len) else $error("read ended before sample");
   a_addr_rd: assert property (p_addr_rd) else $error("address moved during read");
   a_data_wr: assert property (p_data_wr) else $error("data moved during write");
   a_wr_drive: assert property (p_wr_drive) else $error("write without data drive");
   // Once busy lets go of an own read, the byte on the lines must hold still
   property p_rd_data;
      ($fell(busy) && !rd_n && own) |-> rdata_oe ##1 $stable(data);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read byte moved as busy fell");
endmodule

// File: tb/pbio_board_tb.sv
// Self-checking bench: host end and board end joined by the cable bus
`timescale 1ns/1ns
module pbio_board_tb;
   import pbio_pkg::*;
   localparam int BASE = 24;     // Switches of weight 8 and 16 ON
   logic        clock, resetn, psel, penable, pwrite, pready, pslverr, user_busy, clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, user_in, user_out;
   logic [31:0] out_m;           // Expected output latches
   pbio_addr_t  addr_switch;
   logic [3:0]  readback_jumper, rd_strobe_n, wr_strobe;
   logic [3:0]  seen_rd, seen_wr; // Strobes seen since last clear
   int          errors, cmp_count;
   pbio_bus_if bus ();
   pbio_board #(.SAMPLE_CYC(8)) u_pbio_board (.clock, .resetn, .bus, .addr_switch, .readback_jumper,
      .user_in, .user_busy, .user_out, .rd_strobe_n, .wr_strobe);
   pbio_host u_pbio_host (.clock, .resetn, .bus, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   pbio_checker #(.BASE(BASE)) u_pbio_checker (.clock(clock), .resetn(resetn), .addr(bus.addr),
      .wdata(bus.wdata), .wdata_oe(bus.wdata_oe), .rdata(bus.rdata), .rdata_oe(bus.rdata_oe),
      .rd_n(bus.rd_n), .wr(bus.wr), .busy_out(bus.busy_out), .busy_oe(bus.busy_oe),
      .data(bus.data), .busy(bus.busy));
   // Sticky record of strobes, so short pulses are never missed
   always @(posedge clock) begin
      seen_rd <= clr ? 4'h0 : seen_rd | ~rd_strobe_n;
      seen_wr <= clr ? 4'h0 : seen_wr | wr_strobe;
   end
   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         errors++;
         close_out();
      end
      @(posedge clock);
   endtask
   task automatic bus_go(input logic w, input pbio_addr_t a, input pbio_data_t d);
      logic [31:0] q;
      logic        e;
      clr <= 1'h1;
      apb(1'h1, 12'h008, {24'h0, d}, q, e);
      clr <= 1'h0;
      apb(1'h1, 12'h000, {18'h0, a, 6'h0, w, 1'h1}, q, e);
   endtask
   // Poll until the cable cycle ends, then fetch the read byte
   task automatic bus_end(output pbio_data_t r);
      logic [31:0] q;
      logic        e;
      int          n;
      n = 0;
      do begin
         apb(1'h0, 12'h004, 32'h0, q, e);
         n++;
      end while (q[0] !== 1'h0 && n < 200);
      if (q[0] !== 1'h0) begin
         errors++;
         close_out();
      end
      apb(1'h0, 12'h00c, 32'h0, q, e);
      r = q[7:0];
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_write();
      pbio_data_t pat [4];
      pbio_data_t r;
      pat = '{8'h90, 8'h64, 8'hff, 8'h5a};
      for (int p = 0; p < 4; p++) begin
         bus_go(1'h1, pbio_addr_t'(BASE + p), pat[p]);
         bus_end(r);
         out_m[p*8 +: 8] = pat[p];
         chk(user_out, out_m);
         chk({seen_rd, seen_wr}, {4'h0, 4'h1 << p});
      end
      $display("t_write done");
   endtask
   // Second pass changes inputs and fits jumpers on ports 0 and 2
   task automatic t_read();
      logic [31:0] ins [2];
      logic [3:0]  jmp [2];
      pbio_data_t  r;
      ins = '{32'h3c0fe7a1, 32'hc3f0185e};
      jmp = '{4'h0, 4'h5};
      for (int j = 0; j < 2; j++) begin
         user_in <= ins[j];
         readback_jumper <= jmp[j];
         for (int p = 0; p < 4; p++) begin
            bus_go(1'h0, pbio_addr_t'(BASE + p), 8'h00);
            bus_end(r);
            chk(r, jmp[j][p] ? out_m[p*8 +: 8] : ins[j][p*8 +: 8]);
            chk({seen_rd, seen_wr}, {4'h1 << p, 4'h0});
         end
      end
      $display("t_read done");
   endtask
   task automatic t_foreign();
      pbio_addr_t  bad [2];
      pbio_data_t  r;
      logic [31:0] q;
      logic        e;
      bad = '{6'h1c, 6'h17};
      for (int i = 0; i < 2; i++) begin
         bus_go(1'h1, bad[i], 8'h33);
         bus_end(r);
         chk({seen_rd, seen_wr, user_out}, {8'h00, out_m});
         bus_go(1'h0, bad[i], 8'h00);
         bus_end(r);
         chk({seen_rd, r}, {4'h0, 8'hff});
      end
      apb(1'h0, 12'h010, 32'h0, q, e);
      chk(e, 1'h1);
      // Switches of weight 4 and 1 give base 5
      // distinct board range
      addr_switch <= 6'h05;
      bus_go(1'h1, 6'h07, 8'ha5);
      bus_end(r);
      out_m[23:16] = 8'ha5;
      chk({seen_wr, user_out}, {4'h4, out_m});
      addr_switch <= 6'h18;
      $display("t_foreign done");
   endtask
   // User circuitry holds the host off until it lets go
   task automatic t_busy();
      pbio_data_t  r;
      logic [31:0] q;
      logic        e;
      user_busy <= 1'h1;
      bus_go(1'h1, 6'h18, 8'h3c);
      repeat (5) begin
         apb(1'h0, 12'h004, 32'h0, q, e);
         chk(q[1:0], 2'h3);
      end
      user_busy <= 1'h0;
      bus_end(r);
      out_m[7:0] = 8'h3c;
      chk(user_out, out_m);
      $display("t_busy done");
   endtask
   initial begin
      {resetn, psel, penable, pwrite, user_busy} = 5'h0;
      {paddr, pwdata, user_in, out_m} = 108'h0;
      {errors, cmp_count} = 0;
      clr = 1'h1;
      addr_switch = 6'h18;
      readback_jumper = 4'h0;
      repeat (12) @(posedge clock);
      resetn <= 1'h1;
      @(posedge clock);
      chk(user_out, 32'h0);
      t_write();
      t_read();
      t_foreign();
      t_busy();
      close_out();
   end
endmodule
